/* pixel_clock_pkg.sv */
// shared constants, codes and decode helpers for the pixel clock block
package pixel_clock_pkg;

   // register byte offsets on the register bus
   localparam logic [3:0] ADDR_INPUT_SEL = 4'h0;
   localparam logic [3:0] ADDR_OUTPUT_SEL = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_SOFT_RESET = 4'hC;

   // reset values of the selection registers
   localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_SEL_RESET = 8'h3F;

   // output select: bits 5, 4, 2 and 1 all set clear the counter
   localparam logic [7:0] CLEAR_MASK = 8'h36;

   // output select field layout
   localparam int DIV_W = 3;
   localparam int SHIFT_DIV_LSB = 0;
   localparam int VIDEO_DIV_LSB = 3;
   localparam logic [2:0] DIV_CODE_MAX = 3'h5;

   // input select field layout and source codes
   localparam int SRC_W = 4;
   localparam logic [3:0] SRC_ZERO = 4'h0;
   localparam logic [3:0] SRC_ONE = 4'h1;
   localparam logic [3:0] SRC_TWO = 4'h2;
   localparam logic [3:0] SRC_DUAL_P_TTL = 4'h3;
   localparam logic [3:0] SRC_DUAL_N_TTL = 4'h4;
   localparam logic [3:0] SRC_DUAL_ECL = 4'h8;

   // shared counter
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_WRAP = 5'h1F;

   // clock input pins: zero, one, two, dual plus, dual minus
   localparam int NUM_PINS = 5;

   // status register field positions
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_DUAL_TTL = 5;
   localparam int STAT_SHIFT_LSB = 6;
   localparam int STAT_VIDEO_LSB = 9;
   localparam int STAT_CLEAR = 12;

   // soft reset register
   localparam int SOFT_RESET_BIT = 0;

   typedef enum logic {BUS_WAIT, BUS_DONE} bus_state_type;

   // a divide code drives its output only for codes 000 to 101
   function automatic logic div_enabled(input logic [2:0] code);
      div_enabled = (code <= DIV_CODE_MAX);
   endfunction

endpackage

/* pin_sync.sv */
// two flip-flop synchroniser for asynchronous clock pins
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // pins and synchronised levels
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_level
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] level_q;
   logic [W-1:0] level_d;

   always_comb begin
      meta_d = i_pin;
      level_d = meta_q;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_q <= '0;
         level_q <= '0;
      end else begin
         meta_q <= meta_d;
         level_q <= level_d;
      end
   end

   assign o_level = level_q;
endmodule

/* divide_tap.sv */
// one divided output taken from the shared counter
`timescale 1ns/10ps
module divide_tap
   import pixel_clock_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // next counter state and next dot level
   input wire logic [CNT_W-1:0] i_cnt_next,
   input wire logic i_dot_next,
   // active divide code
   input wire logic [DIV_W-1:0] i_code,
   // divided clock level
   output logic o_level
);
   logic level_q;
   logic level_d;
   logic [DIV_W-1:0] bit_sel;

   always_comb begin
      bit_sel = i_code - 3'h1;
      if (!div_enabled(i_code)) begin
         level_d = 1'b0;
      end else if (i_code == 3'h0) begin
         level_d = i_dot_next;
      end else begin
         // inverted bit rises as the lower bits roll over, so the rising
         // edges of every enabled output land on the same dot clock rise
         level_d = ~i_cnt_next[bit_sel];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end

   assign o_level = level_q;
endmodule

/* pixel_clock_select_and_divider.sv */
// clock source selection, shared counter and divided clocks with bus slave
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps

module pixel_clock_select_and_divider
   import pixel_clock_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // clock input pins
   input wire logic i_clock_input_zero,
   input wire logic i_clock_input_one,
   input wire logic i_clock_input_two,
   input wire logic i_dual_mode_clock_input_p,
   input wire logic i_dual_mode_clock_input_n,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // generated clocks
   output logic o_pixel_rate_clock,
   output logic o_shift_clock,
   output logic o_video_timing_clock_out,
   // source mode
   output logic o_dual_input_ecl_mode
);

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_lvl;

   assign pin_raw = {i_dual_mode_clock_input_n, i_dual_mode_clock_input_p,
                     i_clock_input_two, i_clock_input_one,
                     i_clock_input_zero};

   pin_sync #(
      .W(NUM_PINS)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_pin(pin_raw),
      .o_level(pin_lvl)
   );

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [7:0] in_sel_q;
   logic [7:0] in_sel_d;
   logic [7:0] out_sel_q;
   logic [7:0] out_sel_d;
   bus_state_type bus_q;
   bus_state_type bus_d;
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // shared counter state
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [DIV_W-1:0] shift_act_q;
   logic [DIV_W-1:0] shift_act_d;
   logic [DIV_W-1:0] video_act_q;
   logic [DIV_W-1:0] video_act_d;
   logic dot_q;
   logic dot_d;
   logic ecl_q;
   logic ecl_d;

   // bus decode
   logic req;
   logic commit;
   logic wr_lane0;
   logic [31:0] status_word;

   // clock path
   logic src_lvl;
   logic ecl_lvl;
   logic dual_ttl;
   logic dot_rise;
   logic cnt_clear;
   logic wrap;
   logic shift_lvl;
   logic video_lvl;

   // ---------------------------------------------------------------
   // input source decode
   // ---------------------------------------------------------------
   // differential pair read as the plus pin above the minus pin
   assign ecl_lvl = pin_lvl[3] & ~pin_lvl[4];

   always_comb begin
      dual_ttl = 1'b0;
      case (in_sel_q[SRC_W-1:0])
         SRC_ZERO: begin
            src_lvl = pin_lvl[0];
         end
         SRC_ONE: begin
            src_lvl = pin_lvl[1];
         end
         SRC_TWO: begin
            src_lvl = pin_lvl[2];
         end
         SRC_DUAL_P_TTL: begin
            src_lvl = pin_lvl[3];
            dual_ttl = 1'b1;
         end
         SRC_DUAL_N_TTL: begin
            src_lvl = pin_lvl[4];
            dual_ttl = 1'b1;
         end
         SRC_DUAL_ECL: begin
            src_lvl = ecl_lvl;
         end
         default: begin
            // unassigned codes stay on input zero
            src_lvl = pin_lvl[0];
         end
      endcase
   end

   // ---------------------------------------------------------------
   // dot clock, shared counter and staged divide codes
   // ---------------------------------------------------------------
   assign dot_rise = src_lvl & ~dot_q;
   assign cnt_clear = (out_sel_q & CLEAR_MASK) == CLEAR_MASK;
   assign wrap = dot_rise && (cnt_q == CNT_WRAP);

   always_comb begin
      dot_d = src_lvl;
      ecl_d = ~dual_ttl;
      cnt_d = cnt_q;
      shift_act_d = shift_act_q;
      video_act_d = video_act_q;
      if (cnt_clear) begin
         cnt_d = '0;
         shift_act_d = out_sel_q[SHIFT_DIV_LSB +: DIV_W];
         video_act_d = out_sel_q[VIDEO_DIV_LSB +: DIV_W];
      end else if (dot_rise) begin
         cnt_d = cnt_q + 5'h01;
         if (wrap) begin
            shift_act_d = out_sel_q[SHIFT_DIV_LSB +: DIV_W];
            video_act_d = out_sel_q[VIDEO_DIV_LSB +: DIV_W];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dot_q <= 1'b0;
         ecl_q <= 1'b1;
         cnt_q <= '0;
         shift_act_q <= OUTPUT_SEL_RESET[SHIFT_DIV_LSB +: DIV_W];
         video_act_q <= OUTPUT_SEL_RESET[VIDEO_DIV_LSB +: DIV_W];
      end else begin
         dot_q <= dot_d;
         ecl_q <= ecl_d;
         cnt_q <= cnt_d;
         shift_act_q <= shift_act_d;
         video_act_q <= video_act_d;
      end
   end

   // both taps see the same next counter value, so edges line up
   divide_tap u_shift_tap (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_cnt_next(cnt_d),
      .i_dot_next(dot_d),
      .i_code(shift_act_d),
      .o_level(shift_lvl)
   );

   divide_tap u_video_tap (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_cnt_next(cnt_d),
      .i_dot_next(dot_d),
      .i_code(video_act_d),
      .o_level(video_lvl)
   );

   // ---------------------------------------------------------------
   // avalon-mm slave: one wait cycle, then completion
   // ---------------------------------------------------------------
   assign req = i_avs_read | i_avs_write;
   assign commit = req && (bus_q == BUS_DONE);
   assign wr_lane0 = commit && i_avs_write && i_avs_byteenable[0];

   always_comb begin
      status_word = '0;
      status_word[STAT_CNT_LSB +: CNT_W] = cnt_q;
      status_word[STAT_DUAL_TTL] = ~ecl_q;
      status_word[STAT_SHIFT_LSB +: DIV_W] = shift_act_q;
      status_word[STAT_VIDEO_LSB +: DIV_W] = video_act_q;
      status_word[STAT_CLEAR] = cnt_clear;
   end

   always_comb begin
      bus_d = bus_q;
      wait_d = wait_q;
      rdata_d = rdata_q;
      case (bus_q)
         BUS_WAIT: begin
            if (req) begin
               bus_d = BUS_DONE;
               wait_d = 1'b0;
               rdata_d = '0;
               if (i_avs_read) begin
                  case (i_avs_address)
                     ADDR_INPUT_SEL: rdata_d = {24'h00_0000, in_sel_q};
                     ADDR_OUTPUT_SEL: rdata_d = {24'h00_0000, out_sel_q};
                     ADDR_STATUS: rdata_d = status_word;
                     default: rdata_d = '0;
                  endcase
               end
            end
         end
         BUS_DONE: begin
            bus_d = BUS_WAIT;
            wait_d = 1'b1;
         end
         default: begin
            bus_d = BUS_WAIT;
            wait_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bus_q <= BUS_WAIT;
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else begin
         bus_q <= bus_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // selection registers
   // ---------------------------------------------------------------
   always_comb begin
      in_sel_d = in_sel_q;
      out_sel_d = out_sel_q;
      if (wr_lane0) begin
         case (i_avs_address)
            ADDR_INPUT_SEL: begin
               in_sel_d = i_avs_writedata[7:0];
            end
            ADDR_OUTPUT_SEL: begin
               out_sel_d = i_avs_writedata[7:0];
            end
            ADDR_SOFT_RESET: begin
               if (i_avs_writedata[SOFT_RESET_BIT]) begin
                  in_sel_d = INPUT_SEL_RESET;
                  out_sel_d = OUTPUT_SEL_RESET;
               end
            end
            default: begin
               in_sel_d = in_sel_q;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_sel_q <= INPUT_SEL_RESET;
         out_sel_q <= OUTPUT_SEL_RESET;
      end else begin
         in_sel_q <= in_sel_d;
         out_sel_q <= out_sel_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_pixel_rate_clock = dot_q;
   assign o_shift_clock = shift_lvl;
   assign o_video_timing_clock_out = video_lvl;
   assign o_dual_input_ecl_mode = ecl_q;

endmodule

/* pixel_clock_monitor.sv */
// assertion checker for the pixel clock block
`timescale 1ns/10ps
module pixel_clock_monitor
   import pixel_clock_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // clock pins
   input wire logic i_clock_input_zero,
   input wire logic i_clock_input_one,
   input wire logic i_clock_input_two,
   input wire logic i_dual_mode_clock_input_p,
   input wire logic i_dual_mode_clock_input_n,
   // register bus
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // generated clocks
   input wire logic o_pixel_rate_clock,
   input wire logic o_shift_clock,
   input wire logic o_video_timing_clock_out,
   input wire logic o_dual_input_ecl_mode
);
   logic [7:0] in_q, in_d, out_q, out_d, age_q, age_d;
   logic wr;
   // shadow selects and cycles since the last completed write with byte lane 0 enabled
   always_comb begin
      wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
      in_d = in_q;
      out_d = out_q;
      age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
      if (wr) begin
         age_d = 8'h00;
         if (i_avs_address == ADDR_INPUT_SEL)
            in_d = i_avs_writedata[7:0];
         if (i_avs_address == ADDR_OUTPUT_SEL)
            out_d = i_avs_writedata[7:0];
         if (i_avs_address == ADDR_SOFT_RESET && i_avs_writedata[0]) begin
            in_d = INPUT_SEL_RESET;
            out_d = OUTPUT_SEL_RESET;
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_q <= INPUT_SEL_RESET;
         out_q <= OUTPUT_SEL_RESET;
         age_q <= 8'h00;
      end else begin
         in_q <= in_d;
         out_q <= out_d;
         age_q <= age_d;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_answer;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   property p_wait_answer; s_req |=> s_answer; endproperty
   a_wait_answer: assert property (p_wait_answer)
      else $error("register access not answered after one wait cycle");
   property p_wait_one; !o_avs_waitrequest |-> $past(o_avs_waitrequest);
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low twice in a row");
   property p_shift_edge; $rose(o_shift_clock) |-> $rose(o_pixel_rate_clock);
   endproperty
   a_shift_edge: assert property (p_shift_edge)
      else $error("shift clock rose without a dot clock rise");
   property p_align;
      $rose(o_video_timing_clock_out) && age_q == 8'hFF
         && out_q[2:0] <= out_q[5:3] |-> $rose(o_shift_clock);
   endproperty
   a_align: assert property (p_align)
      else $error("video clock edge not aligned with shift clock");
   property p_clear_off;
      age_q > 8'h08 && out_q[5:4] == 2'b11 && out_q[2:1] == 2'b11
         |-> !o_shift_clock && !o_video_timing_clock_out;
   endproperty
   a_clear_off: assert property (p_clear_off)
      else $error("clock output active while counter cleared");
   property p_off_low;
      age_q == 8'hFF && out_q[2:1] == 2'b11 |-> !o_shift_clock;
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("disabled shift clock not low");
   property p_dot_follow;
      age_q > 8'h08 && in_q == 8'h00
         |-> o_pixel_rate_clock == $past(i_clock_input_zero, 3);
   endproperty
   a_dot_follow: assert property (p_dot_follow)
      else $error("dot clock does not follow input zero");
   property p_ecl;
      age_q > 8'h04 |-> o_dual_input_ecl_mode
         == !(in_q[3:0] == 4'h3 || in_q[3:0] == 4'h4);
   endproperty
   a_ecl: assert property (p_ecl)
      else $error("dual input mode flag wrong");
endmodule
bind pixel_clock_select_and_divider pixel_clock_monitor pixel_clock_monitor_i (.*);

/* clock_far_side.sv */
// clock pin sources and receiver of the generated clocks
`timescale 1ns/10ps
module clock_far_side (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // stops every clock pin low
   input wire logic i_hold,
   // clocks coming back from the block
   input wire logic i_dot,
   input wire logic i_shift,
   input wire logic i_video,
   // pins zero, one, two, dual plus, dual minus
   output logic [4:0] o_pins,
   // last measured periods in system cycles
   output int o_dot_per,
   output int o_shift_per,
   output int o_video_per
);
   int tick;
   int since [3];
   int per [3];
   logic [2:0] prev;
   logic [2:0] now_v;
   initial o_pins = 5'h00;
   assign now_v = {i_video, i_shift, i_dot};
   assign o_dot_per = per[0];
   assign o_shift_per = per[1];
   assign o_video_per = per[2];
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pins <= 5'h00;
         prev <= 3'h0;
         tick <= 0;
         since <= '{default: 0};
         per <= '{default: 0};
      end else begin
         // pin k has a period of 2 * (k + 2) cycles; held pins rest low
         tick <= i_hold ? 0 : tick + 1;
         for (int k = 0; k < 5; k++)
            o_pins[k] <= !i_hold && ((tick / (k + 2)) % 2 == 1);
         for (int k = 0; k < 3; k++) begin
            since[k] <= since[k] + 1;
            if (now_v[k] && !prev[k]) begin
               per[k] <= since[k];
               since[k] <= 1;
            end
         end
         prev <= now_v;
      end
   end
endmodule

/* test_pixel_clock_select_and_divider.sv */
// self-checking testbench for the pixel clock block
`timescale 1ns/10ps
module test_pixel_clock_select_and_divider
   import pixel_clock_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [4:0] pins;
   logic i_clock_input_zero, i_clock_input_one, i_clock_input_two;
   logic i_dual_mode_clock_input_p, i_dual_mode_clock_input_n;
   logic [3:0] i_avs_address = 4'h0;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0000_0000;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest, o_pixel_rate_clock, o_shift_clock;
   logic o_video_timing_clock_out, o_dual_input_ecl_mode;
   logic hold = 1'b0;
   int dot_per, shift_per, video_per;
   int errors = 0;
   int checks = 0;
   int in_m = 0;
   int out_m = 63;
   int codes[$] = '{0, 1, 2, 3, 4, 8};
   assign {i_dual_mode_clock_input_n, i_dual_mode_clock_input_p,
      i_clock_input_two, i_clock_input_one, i_clock_input_zero} = pins;
   pixel_clock_select_and_divider pixel_clock_select_and_divider_i (.*);
   clock_far_side clock_far_side_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_hold(hold), .i_dot(o_pixel_rate_clock), .i_shift(o_shift_clock),
      .i_video(o_video_timing_clock_out), .o_pins(pins),
      .o_dot_per(dot_per), .o_shift_per(shift_per),
      .o_video_per(video_per));
   always #2.5 i_clk = ~i_clk;
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_read <= !w;
      i_avs_write <= w;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         give_verdict;
      end
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
   endtask
   // writes the register and updates the model the same way
   task automatic put(input logic [3:0] a, input logic [7:0] d,
         input logic [3:0] b);
      logic [31:0] q;
      i_avs_byteenable <= b;
      bus(1'b1, a, {24'h00_0000, d}, q);
      if (b[0] && a == ADDR_INPUT_SEL)
         in_m = d;
      if (b[0] && a == ADDR_OUTPUT_SEL)
         out_m = d;
      if (b[0] && a == ADDR_SOFT_RESET && d[0]) begin
         in_m = INPUT_SEL_RESET;
         out_m = OUTPUT_SEL_RESET;
      end
   endtask
   task automatic get(input logic [3:0] a, input int e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check("readdata", q, 32'(e));
   endtask
   initial begin
      logic [7:0] v;
      logic [31:0] q;
      void'($urandom(32'h511e_4dd5));
      repeat (20) @(posedge i_clk);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      get(ADDR_INPUT_SEL, in_m);
      get(ADDR_OUTPUT_SEL, out_m);
      idle(60);
      check("dot period", dot_per, 4);
      foreach (codes[k]) begin
         put(ADDR_INPUT_SEL, 8'(codes[k]), 4'h1);
         idle(60);
         get(ADDR_INPUT_SEL, in_m);
         check("ecl", o_dual_input_ecl_mode,
            codes[k] != 3 && codes[k] != 4);
         if (k < 5)
            check("dot period", dot_per, 2 * (k + 2));
      end
      put(ADDR_INPUT_SEL, 8'h00, 4'h1);
      for (int c = 0; c < 6; c++) begin
         v = 8'($urandom % 6);
         put(ADDR_OUTPUT_SEL, {2'b00, v[2:0], 3'(c)}, 4'h1);
         idle(520);
         check("shift period", shift_per, 4 << c);
         check("video period", video_per, 4 << v);
      end
      hold <= 1'b1;
      idle(4);
      put(ADDR_OUTPUT_SEL, 8'h3F, 4'h1);
      idle(10);
      bus(1'b0, ADDR_STATUS, 32'h0000_0000, q);
      check("status", q & 32'h0000_101F, 32'h0000_1000);
      hold <= 1'b0;
      put(ADDR_OUTPUT_SEL, 8'h0E, 4'h1);
      idle(500);
      check("shift level", o_shift_clock, 1'b0);
      check("video period", video_per, 8);
      put(4'h2, 8'($urandom), 4'h1);
      get(4'h2, 0);
      put(ADDR_INPUT_SEL, 8'h02, 4'h0);
      get(ADDR_INPUT_SEL, in_m);
      put(ADDR_SOFT_RESET, 8'h01, 4'h1);
      get(ADDR_INPUT_SEL, in_m);
      get(ADDR_OUTPUT_SEL, out_m);
      give_verdict;
   end
endmodule
